// *** core/can_error_state_fifo_status.sv ***
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"
module can_error_state_fifo_status (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             clk_en,
    // ------------------------------------------------------------
    // counters and fifo flags from the frame engine
    // ------------------------------------------------------------
    input  wire logic [8:0]                       tx_fault_count,
    input  wire logic [8:0]                       rx_fault_count,
    input  wire logic                             bus_off_exit,
    input  wire logic [`FIFO_COUNT*`FIFO_IRQ_W-1:0] fifo_irq_flags,
    input  wire logic [`FIFO_COUNT*`FIFO_IRQ_W-1:0] fifo_irq_enables,
    // ------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------
    input  wire logic [`ADDR_W-1:0]               avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [31:0]                      avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic [31:0]                           avs_readdata,
    output logic                                  avs_waitrequest,
    output logic                                  tx_bus_off_flag
);
    can_status_pkg::bus_state_t state_r;
    logic [8:0]                 tx_cnt_r;
    logic [8:0]                 rx_cnt_r;
    logic                       bus_off_r;
    logic [31:0]                fifo_pend_r;
    logic [31:0]                err_word_r;
    logic [31:0]                avs_readdata_r;
    logic [31:0]                rdata_nxt;
    logic [7:0]                 tx_vis;
    logic [7:0]                 rx_vis;
    logic [5:0]                 flags;
    logic [`FIFO_COUNT-1:0]     pending;

    // ------------------------------------------------------------
    // sampled counters; bus-off latched until the engine leaves it
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_r <= 9'h000;
            rx_cnt_r <= 9'h000;
        end else if (clk_en) begin
            tx_cnt_r <= tx_fault_count;
            rx_cnt_r <= rx_fault_count;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_off_r <= 1'b0;
        end else if (clk_en) begin
            if (tx_cnt_r >= `BUS_OFF_LIMIT)
                bus_off_r <= 1'b1;
            else if (bus_off_exit)
                bus_off_r <= 1'b0;
        end
    end

    fault_state_decode u_decode (
        .tx_cnt       (tx_cnt_r),
        .rx_cnt       (rx_cnt_r),
        .bus_off_hold (bus_off_r),
        .tx_vis       (tx_vis),
        .rx_vis       (rx_vis),
        .flags        (flags)
    );

    fifo_pending_or u_pend (
        .irq_flags   (fifo_irq_flags),
        .irq_enables (fifo_irq_enables),
        .pending     (pending)
    );

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_word_r  <= `ZERO_WORD;
            fifo_pend_r <= `ZERO_WORD;
        end else if (clk_en) begin
            err_word_r <= {10'h000, flags,
                           tx_vis, rx_vis};
            fifo_pend_r <= pending;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            tx_bus_off_flag <= 1'b0;
        else if (clk_en)
            tx_bus_off_flag <= flags[5];
    end

    // ------------------------------------------------------------
    // bus slave: one wait cycle, answer in ST_RESP
    // ------------------------------------------------------------
    always_comb begin
        unique case (avs_address)
            `ERR_COUNT_OFS: rdata_nxt = err_word_r;
            `FIFO_PEND_OFS: rdata_nxt = fifo_pend_r;
            default:        rdata_nxt = `UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r        <= can_status_pkg::ST_IDLE;
            avs_readdata_r <= `ZERO_WORD;
        end else if (clk_en) begin
            unique case (state_r)
                can_status_pkg::ST_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_r <= can_status_pkg::ST_RESP;
                        if (avs_read)
                            avs_readdata_r <= rdata_nxt;
                    end
                end
                can_status_pkg::ST_RESP: begin
                    state_r <= can_status_pkg::ST_IDLE;
                end
                default: state_r <= can_status_pkg::ST_IDLE;
            endcase
        end
    end

    assign avs_readdata    = avs_readdata_r;
    // a response held by a low clock enable keeps the master waiting
    assign avs_waitrequest = (avs_read || avs_write)
                             && !(state_r == can_status_pkg::ST_RESP && clk_en);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_busoff_flag: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && tx_cnt_r >= `BUS_OFF_LIMIT |=> err_word_r[`TX_BUS_OFF_BIT])
        else $error("bus-off bit missing");
    a_tx_passive: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> err_word_r[`TX_PASSIVE_BIT] == ($past(tx_cnt_r) >= `PASSIVE_LIMIT))
        else $error("tx passive bit wrong");
    a_rx_passive: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> err_word_r[`RX_PASSIVE_BIT] == ($past(rx_cnt_r) >= `PASSIVE_LIMIT))
        else $error("rx passive bit wrong");
    a_tx_warn: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> err_word_r[`TX_WARN_BIT] ==
            ($past(tx_cnt_r) >= `WARN_LIMIT && $past(tx_cnt_r) < `PASSIVE_LIMIT))
        else $error("tx warning bit wrong");
    a_rx_warn: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> err_word_r[`RX_WARN_BIT] ==
            ($past(rx_cnt_r) >= `WARN_LIMIT && $past(rx_cnt_r) < `PASSIVE_LIMIT))
        else $error("rx warning bit wrong");
    a_any_warn: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[`ANY_WARN_BIT] == (err_word_r[`TX_WARN_BIT] | err_word_r[`RX_WARN_BIT]))
        else $error("combined warning wrong");
    a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[31:22] == 10'h000)
        else $error("upper bits not zero");
    a_count_field: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !tx_cnt_r[8] |=> err_word_r[15:8] == $past(tx_cnt_r[7:0])
            && err_word_r[7:0] == ($past(rx_cnt_r[8]) ? `CNT_SAT : $past(rx_cnt_r[7:0])))
        else $error("count fields wrong");
    a_fifo_pend: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |=> fifo_pend_r == $past(pending))
        else $error("fifo pending word wrong");
    a_busoff_hold: assert property (@(posedge clk) disable iff (!rst_n)
        bus_off_r && !bus_off_exit |=> err_word_r[`TX_BUS_OFF_BIT] || !$past(clk_en))
        else $error("bus-off not held");

    // ------------------------------------------------------------
    // check helpers: request seen and length of the wait phase
    // ------------------------------------------------------------
    logic       bus_req;
    logic [1:0] wait_len_r;

    assign bus_req = avs_read || avs_write;

    // counts enabled cycles with waitrequest high, stops at its top value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_len_r <= 2'h0;
        end else if (clk_en) begin
            if (!avs_waitrequest)
                wait_len_r <= 2'h0;
            else if (wait_len_r != 2'h3)
                wait_len_r <= wait_len_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // bus handshake sequences
    // ------------------------------------------------------------
    sequence s_take;
        clk_en && bus_req && (state_r == can_status_pkg::ST_IDLE);
    endsequence

    sequence s_take_read;
        s_take ##0 avs_read;
    endsequence

    sequence s_wait_done;
        s_take ##1 (clk_en && bus_req);
    endsequence

    sequence s_answer;
        clk_en && bus_req && !avs_waitrequest;
    endsequence

    // ------------------------------------------------------------
    // bus handshake checks
    // ------------------------------------------------------------
    a_state_onehot: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot(state_r))
        else $error("bus state not one-hot");
    a_take_wait: assert property (@(posedge clk) disable iff (!rst_n)
        s_take |-> avs_waitrequest)
        else $error("request taken without a wait cycle");
    a_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
        s_wait_done |-> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    a_wait_bound: assert property (@(posedge clk) disable iff (!rst_n)
        wait_len_r <= 2'h1)
        else $error("wait phase longer than one cycle");
    a_idle_ready: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_req |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    a_answer_idle: assert property (@(posedge clk) disable iff (!rst_n)
        s_answer |=> state_r == can_status_pkg::ST_IDLE)
        else $error("bus did not return to idle");
    a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
        s_take_read |=> avs_readdata ==
            (($past(avs_address) == `ERR_COUNT_OFS) ? $past(err_word_r) :
             ($past(avs_address) == `FIFO_PEND_OFS) ? $past(fifo_pend_r) : `UNMAPPED_DATA))
        else $error("read data not the addressed word");
    a_read_stand: assert property (@(posedge clk) disable iff (!rst_n)
        !(clk_en && avs_read && state_r == can_status_pkg::ST_IDLE) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_write_noload: assert property (@(posedge clk) disable iff (!rst_n)
        s_take ##0 avs_write |=> $stable(avs_readdata))
        else $error("write changed read data");

    // ------------------------------------------------------------
    // clock-enable freeze checks
    // ------------------------------------------------------------
    a_freeze_bus: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(state_r) && $stable(avs_readdata) && $stable(wait_len_r))
        else $error("bus state moved while frozen");
    a_freeze_counts: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(tx_cnt_r) && $stable(rx_cnt_r) && $stable(bus_off_r))
        else $error("counters moved while frozen");
    a_freeze_words: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(err_word_r) && $stable(fifo_pend_r) && $stable(tx_bus_off_flag))
        else $error("status words moved while frozen");

    // ------------------------------------------------------------
    // bus-off sequences and checks
    // ------------------------------------------------------------
    sequence s_bo_enter;
        clk_en && (tx_cnt_r >= `BUS_OFF_LIMIT);
    endsequence

    sequence s_bo_leave;
        clk_en && bus_off_r && bus_off_exit && (tx_cnt_r < `BUS_OFF_LIMIT);
    endsequence

    a_busoff_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_bo_enter |=> bus_off_r)
        else $error("bus-off not latched");
    a_busoff_keep: assert property (@(posedge clk) disable iff (!rst_n)
        bus_off_r && !bus_off_exit |=> bus_off_r)
        else $error("bus-off dropped without exit");
    a_busoff_leave: assert property (@(posedge clk) disable iff (!rst_n)
        s_bo_leave |=> !bus_off_r)
        else $error("bus-off kept after exit");
    a_flag_port: assert property (@(posedge clk) disable iff (!rst_n)
        tx_bus_off_flag == err_word_r[`TX_BUS_OFF_BIT])
        else $error("bus-off port differs from bit");
    a_tx_sat: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && tx_cnt_r[8] |=> err_word_r[`TX_CNT_LSB +: 8] == `CNT_SAT)
        else $error("tx count not saturated");
    a_rx_sat: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rx_cnt_r[8] |=> err_word_r[`RX_CNT_LSB +: 8] == `CNT_SAT)
        else $error("rx count not saturated");

    // ------------------------------------------------------------
    // state bits against the visible counts
    // ------------------------------------------------------------
    a_tx_warn_range: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[`TX_WARN_BIT] |-> !err_word_r[`TX_PASSIVE_BIT] && !err_word_r[`TX_CNT_LSB + 7]
            && err_word_r[`TX_CNT_LSB +: 8] >= `WARN_LIMIT)
        else $error("tx warning outside its range");
    a_rx_warn_range: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[`RX_WARN_BIT] |-> !err_word_r[`RX_PASSIVE_BIT] && !err_word_r[`RX_CNT_LSB + 7]
            && err_word_r[`RX_CNT_LSB +: 8] >= `WARN_LIMIT)
        else $error("rx warning outside its range");
    a_tx_passive_cnt: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[`TX_PASSIVE_BIT] |-> err_word_r[`TX_CNT_LSB + 7])
        else $error("tx passive with low count");
    a_rx_passive_cnt: assert property (@(posedge clk) disable iff (!rst_n)
        err_word_r[`RX_PASSIVE_BIT] |-> err_word_r[`RX_CNT_LSB + 7])
        else $error("rx passive with low count");

    // ------------------------------------------------------------
    // input to status word: two enabled edges
    // ------------------------------------------------------------
    sequence s_two_en;
        clk_en ##1 clk_en;
    endsequence

    a_rx_lag: assert property (@(posedge clk) disable iff (!rst_n)
        s_two_en |=> err_word_r[`RX_PASSIVE_BIT] == ($past(rx_fault_count, 2) >= `PASSIVE_LIMIT))
        else $error("rx passive lag wrong");
    a_tx_lag_bo: assert property (@(posedge clk) disable iff (!rst_n)
        s_two_en ##0 ($past(tx_fault_count) >= `BUS_OFF_LIMIT) |=> err_word_r[`TX_BUS_OFF_BIT])
        else $error("bus-off lag wrong");
    a_tx_lag_warn: assert property (@(posedge clk) disable iff (!rst_n)
        s_two_en |=> err_word_r[`TX_WARN_BIT] ==
            ($past(tx_fault_count, 2) >= `WARN_LIMIT && $past(tx_fault_count, 2) < `PASSIVE_LIMIT))
        else $error("tx warning lag wrong");
    a_rx_lag_warn: assert property (@(posedge clk) disable iff (!rst_n)
        s_two_en |=> err_word_r[`RX_WARN_BIT] ==
            ($past(rx_fault_count, 2) >= `WARN_LIMIT && $past(rx_fault_count, 2) < `PASSIVE_LIMIT))
        else $error("rx warning lag wrong");

    // ------------------------------------------------------------
    // fifo pending checks
    // ------------------------------------------------------------
    a_pend_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && ((fifo_irq_flags & fifo_irq_enables) == '0) |=> fifo_pend_r == `ZERO_WORD)
        else $error("pending word not clear");
    for (genvar g = 0; g < `FIFO_COUNT; g++) begin : g_pend_chk
        a_pend_bit: assert property (@(posedge clk) disable iff (!rst_n)
            clk_en |=> fifo_pend_r[g] == (|($past(fifo_irq_flags[g*`FIFO_IRQ_W +: `FIFO_IRQ_W])
                & $past(fifo_irq_enables[g*`FIFO_IRQ_W +: `FIFO_IRQ_W]))))
            else $error("fifo pending bit wrong");
    end
endmodule // can_error_state_fifo_status
`default_nettype wire

// *** core/fault_state_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"
module fault_state_decode (
    input  wire logic [8:0] tx_cnt,
    input  wire logic [8:0] rx_cnt,
    input  wire logic       bus_off_hold,
    output logic [7:0]      tx_vis,
    output logic [7:0]      rx_vis,
    output logic [5:0]      flags
);
    function automatic logic in_warn(input logic [8:0] c);
        in_warn = (c >= `WARN_LIMIT) && (c < `PASSIVE_LIMIT);
    endfunction

    function automatic logic [7:0] sat8(input logic [8:0] c);
        sat8 = c[8] ? `CNT_SAT : c[7:0];
    endfunction

    always_comb begin
        tx_vis   = sat8(tx_cnt);
        rx_vis   = sat8(rx_cnt);
        flags[5] = (tx_cnt >= `BUS_OFF_LIMIT) || bus_off_hold;
        flags[4] = tx_cnt >= `PASSIVE_LIMIT;
        flags[3] = rx_cnt >= `PASSIVE_LIMIT;
        flags[2] = in_warn(tx_cnt);
        flags[1] = in_warn(rx_cnt);
        flags[0] = in_warn(tx_cnt) || in_warn(rx_cnt);
    end
endmodule // fault_state_decode
`default_nettype wire

// *** core/fifo_pending_or.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"
module fifo_pending_or (
    input  wire logic [`FIFO_COUNT*`FIFO_IRQ_W-1:0] irq_flags,
    input  wire logic [`FIFO_COUNT*`FIFO_IRQ_W-1:0] irq_enables,
    output logic [`FIFO_COUNT-1:0]                  pending
);
    // ------------------------------------------------------------
    // per-fifo reduction of enabled flags
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `FIFO_COUNT; i++) begin
            pending[i] = |(irq_flags[i*`FIFO_IRQ_W +: `FIFO_IRQ_W]
                         & irq_enables[i*`FIFO_IRQ_W +: `FIFO_IRQ_W]);
        end
    end
endmodule // fifo_pending_or
`default_nettype wire

// *** dv/fault_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fault_engine_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [8:0] tx_target,
    input  wire logic [8:0] rx_target,
    input  wire logic       leave_req,
    output logic [8:0]      tx_fault_count,
    output logic [8:0]      rx_fault_count,
    output logic            bus_off_exit
);
    // counters move only on a clock edge, as the frame engine would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_fault_count <= 9'h000;
            rx_fault_count <= 9'h000;
            bus_off_exit   <= 1'b0;
        end else begin
            if (load) begin
                tx_fault_count <= tx_target;
                rx_fault_count <= rx_target;
            end
            bus_off_exit <= leave_req;
        end
    end
endmodule // fault_engine_model
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"
module testbench;
    logic clk = 0, rst_n = 0, ld = 0, lv = 0, rd_r = 0, wr_r = 0, ce = 1;
    logic [8:0] tx_t = 9'h000, rx_t = 9'h000, txc, rxc;
    logic boe, wreq, bo_flag;
    logic [255:0] fl = '0, en = '0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdat, d;
    int mismatches = 0, check_count = 0;
    int tv[8] = '{0, 95, 96, 127, 128, 255, 256, 300};

    always #5 clk = ~clk;

    fault_engine_model u_eng (.clk(clk), .rst_n(rst_n), .load(ld), .tx_target(tx_t), .rx_target(rx_t),
        .leave_req(lv), .tx_fault_count(txc), .rx_fault_count(rxc), .bus_off_exit(boe));

    can_error_state_fifo_status u_dut (.clk(clk), .rst_n(rst_n), .clk_en(ce), .tx_fault_count(txc),
        .rx_fault_count(rxc), .bus_off_exit(boe), .fifo_irq_flags(fl), .fifo_irq_enables(en),
        .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .tx_bus_off_flag(bo_flag));

    // ------------------------------------------------------------
    // bus access and checking
    // ------------------------------------------------------------
    task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] v, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= v;
        wr_r <= w;
        rd_r <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) mismatches++;
        q = rdat;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    task automatic setc(input int t, input int r);
        @(posedge clk);
        tx_t <= t[8:0];
        rx_t <= r[8:0];
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic setf(input logic [255:0] f, input logic [255:0] e);
        @(posedge clk);
        fl <= f;
        en <= e;
        repeat (3) @(posedge clk);
    endtask

    function automatic logic [31:0] ew(input int t, input int r, input bit h);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[15:8] = (t > 255) ? 8'hFF : t[7:0];
        w[7:0]  = (r > 255) ? 8'hFF : r[7:0];
        w[21] = (t >= 256) || h;
        w[20] = t >= 128;
        w[19] = r >= 128;
        w[18] = (t >= 96) && (t < 128);
        w[17] = (r >= 96) && (r < 128);
        w[16] = w[18] | w[17];
        return w;
    endfunction

    task automatic test_done;
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk("err_rst", `ERR_COUNT_OFS, 32'h0000_0000);
        rchk("fifo_rst", `FIFO_PEND_OFS, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            setc(tv[i], tv[7-i]);
            rchk("err_word", `ERR_COUNT_OFS, ew(tv[i], tv[7-i], 1'b0));
        end
        xfer(`ERR_COUNT_OFS, 1'b1, 32'hFFFF_FFFF, d);
        rchk("err_ro", `ERR_COUNT_OFS, ew(300, 0, 1'b0));
        rchk("unmapped", 4'h8, 32'h0000_0000);
        setc(50, 130);
        rchk("bo_held", `ERR_COUNT_OFS, ew(50, 130, 1'b1));
        chk("bo_port", 32'h1, {31'h0, bo_flag});
        @(posedge clk);
        lv <= 1'b1;
        @(posedge clk);
        lv <= 1'b0;
        repeat (3) @(posedge clk);
        rchk("bo_left", `ERR_COUNT_OFS, ew(50, 130, 1'b0));
        chk("bo_port0", 32'h0, {31'h0, bo_flag});
        ce <= 1'b0;
        setc(300, 0);
        chk("bo_frozen", 32'h0, {31'h0, bo_flag});
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk("bo_thawed", 32'h1, {31'h0, bo_flag});
        rchk("thawed", `ERR_COUNT_OFS, ew(300, 0, 1'b0));
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rchk("err_rst2", `ERR_COUNT_OFS, 32'h0000_0000);
        chk("bo_rst", 32'h0, {31'h0, bo_flag});
        for (int k = 0; k < 32; k++) begin
            setf(256'h1 << (k * 8 + k % 8), '0);
            rchk("fifo_masked", `FIFO_PEND_OFS, 32'h0000_0000);
            setf(256'h1 << (k * 8 + k % 8), 256'h1 << (k * 8 + k % 8));
            rchk("fifo_pend", `FIFO_PEND_OFS, 32'h1 << k);
        end
        setf('0, {256{1'b1}});
        rchk("fifo_clear", `FIFO_PEND_OFS, 32'h0000_0000);
        test_done();
    end

    initial begin
        #100us;
        mismatches++;
        test_done();
    end
endmodule // testbench
`default_nettype wire

// *** shared/can_status_pkg.sv ***
`default_nettype none
package can_status_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } bus_state_t;

    typedef logic [8:0] fault_count_t;
endpackage
`default_nettype wire

// *** shared/can_status_regs.svh ***
`ifndef CAN_STATUS_REGS_SVH
`define CAN_STATUS_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define ERR_COUNT_OFS      4'h0
`define FIFO_PEND_OFS      4'h4
`define ADDR_W             4

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RX_CNT_LSB         0
`define TX_CNT_LSB         8
`define ANY_WARN_BIT       16
`define RX_WARN_BIT        17
`define TX_WARN_BIT        18
`define RX_PASSIVE_BIT     19
`define TX_PASSIVE_BIT     20
`define TX_BUS_OFF_BIT     21

// ------------------------------------------------------------
// thresholds and widths
// ------------------------------------------------------------
`define WARN_LIMIT         9'h060
`define PASSIVE_LIMIT      9'h080
`define BUS_OFF_LIMIT      9'h100
`define CNT_SAT            8'hFF
`define FIFO_COUNT         32
`define FIFO_IRQ_W         8
`define UNMAPPED_DATA      32'h0000_0000
`define ZERO_WORD          32'h0000_0000
`endif
